// >>> hdl/sts_gap_timer.sv
// holds off the next frame for the short or long interframe gap
`timescale 1ns/100ps
module sts_gap_timer
	import sts_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        frame_done,
	input  wire logic        frame_long,
	input  wire logic [15:0] short_gap_attr,
	input  wire logic [15:0] long_gap_attr,
	output logic             gap_busy
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        busy;
	} sts_gap_state_t;

	sts_gap_state_t st;
	sts_gap_state_t next_st;
	logic [15:0]    gap_len;

	// ------------------------------------------------------------
	// gap countdown
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		gap_len = frame_long ? long_gap_attr : short_gap_attr;
		if (frame_done)
		begin
			next_st.cnt  = gap_len;
			next_st.busy = gap_len != 16'h0000;
		end
		else if (st.cnt > 16'h0001)
			next_st.cnt = st.cnt - 16'h0001;
		else
		begin
			next_st.cnt  = 16'h0000;
			next_st.busy = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign gap_busy = st.busy;

endmodule : sts_gap_timer

// >>> hdl/sts_order_calc.sv
// derives interval, active duration and slot length from the two orders
`timescale 1ns/100ps
module sts_order_calc
	import sts_pkg::*;
(
	input  wire logic [3:0]  beacon_order,
	input  wire logic [3:0]  active_order,
	output logic      [23:0] beacon_interval,
	output logic      [23:0] active_duration,
	output logic      [23:0] slot_len,
	output logic             beacon_net,
	output logic             active_none,
	output logic             cfg_ok
);

	// ------------------------------------------------------------
	// order decoding
	// ------------------------------------------------------------
	assign beacon_net      = beacon_order <= ORDER_MAX;
	assign active_none     = active_order == ORDER_OFF;
	assign cfg_ok          = beacon_net ? (active_order <= beacon_order)
		: (active_order == ORDER_OFF);
	assign beacon_interval = BASE_SUPERFRAME_LEN << beacon_order;
	assign active_duration = BASE_SUPERFRAME_LEN << active_order;
	assign slot_len        = BASE_SLOT_LEN << active_order;

endmodule : sts_order_calc

// >>> hdl/sts_pkg.sv
// package: constants, register map and types of the superframe timing scheduler
package sts_pkg;

	// ------------------------------------------------------------
	// timing constants, counted in optical clocks
	// ------------------------------------------------------------
	localparam int          CNT_W                = 24;
	localparam logic [23:0] BASE_SLOT_LEN        = 24'h00003c;
	localparam logic [4:0]  SLOT_COUNT_CONST     = 5'h10;
	localparam logic [23:0] BASE_SUPERFRAME_LEN  = 24'h0003c0;
	localparam logic [23:0] MIN_CONTENTION_LEN   = 24'h0001b8;
	localparam logic [3:0]  ORDER_MAX            = 4'he;
	localparam logic [3:0]  ORDER_OFF            = 4'hf;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL             = 8'h00;
	localparam logic [7:0]  OFS_FRAME            = 8'h04;
	localparam logic [7:0]  OFS_GAP              = 8'h08;
	localparam logic [7:0]  OFS_FSK              = 8'h0c;
	localparam logic [7:0]  OFS_DRIFT            = 8'h10;
	localparam logic [7:0]  OFS_STATUS           = 8'h14;
	localparam logic [7:0]  OFS_COUNT            = 8'h18;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int          CTRL_BO_POS          = 0;
	localparam int          CTRL_AO_POS          = 4;
	localparam int          CTRL_EN_BIT          = 8;
	localparam int          CTRL_RXIDLE_BIT      = 9;
	localparam int          CTRL_VIS_BIT         = 10;
	localparam int          CTRL_INFRA_BIT       = 11;
	localparam int          CTRL_MODE_POS        = 12;
	localparam int          CTRL_BREQ_BIT        = 16;
	localparam int          CTRL_LP_BIT          = 17;
	localparam int          FRAME_CFP_POS        = 0;
	localparam int          FRAME_GROW_BIT       = 15;
	localparam int          FRAME_BLEN_POS       = 16;
	localparam int          GAP_SHORT_POS        = 0;
	localparam int          GAP_LONG_POS         = 16;
	localparam int          FSK_IDLE_POS         = 0;
	localparam int          FSK_SYNC_POS         = 16;
	localparam int          FSK_DATA_POS         = 20;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] CTRL_RST             = 32'h000000ff;
	localparam logic [31:0] FRAME_RST            = 32'h00200010;
	localparam logic [31:0] GAP_RST              = 32'h00280010;
	localparam logic [31:0] FSK_RST              = 32'h00420000;
	localparam logic [7:0]  DRIFT_RST            = 8'h00;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PER_BEACON     = 2'b00,
		PER_CONTENTION = 2'b01,
		PER_CFP        = 2'b11,
		PER_INACTIVE   = 2'b10
	} sts_period_t;

	typedef enum logic [1:0] {
		FSK_FDP  = 2'b00,
		FSK_SYNC = 2'b01,
		FSK_DATA = 2'b11,
		FSK_IDLE = 2'b10
	} sts_fsk_t;

	typedef enum logic [1:0] {
		MODE_BEACON_NET  = 2'b00,
		MODE_UNDERSAMPLED = 2'b01,
		MODE_PULSE_POS   = 2'b10,
		MODE_ROLLING_FREQ = 2'b11
	} sts_mode_t;

	typedef enum logic [1:0] {
		ACC_NONE      = 2'b00,
		ACC_SLOTTED   = 2'b01,
		ACC_UNSLOTTED = 2'b10,
		ACC_DIRECT    = 2'b11
	} sts_access_t;

endpackage : sts_pkg

// >>> hdl/sts_scheduler.sv
// superframe timing scheduler: apb registers, superframe counter, period flags
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
module sts_scheduler
	import sts_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        beacon_req_in,
	input  wire logic [23:0] tx_len,
	input  wire logic        tx_busy,
	input  wire logic        slot_used,
	input  wire logic        slot_uplink,
	input  wire logic        frame_done,
	input  wire logic        frame_long,
	input  wire logic        pkt_done,
	output sts_period_t      period,
	output logic      [4:0]  slot_index,
	output logic             slot_start,
	output logic             beacon_start,
	output sts_access_t      access,
	output logic             cca_enable,
	output logic             tx_fits,
	output logic             gts_allowed,
	output logic             rx_enable,
	output logic             idle_pattern,
	output logic             gap_busy,
	output sts_fsk_t         fsk_kind,
	output logic             freq_label_en,
	output logic             low_power_ok
);

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] frame;
		logic [31:0] gap;
		logic [31:0] fsk;
		logic [7:0]  drift;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [23:0] cnt;
		logic [23:0] slot_cnt;
		logic [4:0]  slot_idx;
		logic        running;
		logic        beacon_once;
		sts_period_t period;
		logic        slot_start;
		logic        beacon_start;
		sts_access_t access;
		logic        cca_enable;
		logic        tx_fits;
		logic        gts_allowed;
		logic        rx_enable;
		logic        idle_pattern;
		sts_fsk_t    fsk_st;
		logic [7:0]  fsk_cnt;
		logic [15:0] fsk_idle;
		logic        freq_label_en;
		logic        low_power_ok;
	} sts_state_t;

	sts_state_t  st;
	sts_state_t  next_st;

	logic [23:0] beacon_interval;
	logic [23:0] active_duration;
	logic [23:0] slot_len;
	logic        beacon_net;
	logic        active_none;
	logic        cfg_ok;
	logic        gap_busy_i;

	logic        setup;
	logic        wr;
	logic        breq;
	logic        enabled;
	logic        sframe;
	logic        nonbeacon;
	logic [1:0]  mode;
	logic [4:0]  cfp_first;
	logic [23:0] beacon_len;
	logic [23:0] cfp_bound;
	logic [23:0] wrap_at;
	logic [23:0] period_end;
	logic [23:0] ifs_len;
	logic        cfp_ok;
	logic        limited;
	logic [3:0]  sync_count;
	logic [7:0]  data_count;
	logic [15:0] inactive_len;

	// ------------------------------------------------------------
	// order arithmetic and gap timer
	// ------------------------------------------------------------
	sts_order_calc u_order (
		.beacon_order    (st.ctrl[CTRL_BO_POS +: 4]),
		.active_order    (st.ctrl[CTRL_AO_POS +: 4]),
		.beacon_interval (beacon_interval),
		.active_duration (active_duration),
		.slot_len        (slot_len),
		.beacon_net      (beacon_net),
		.active_none     (active_none),
		.cfg_ok          (cfg_ok)
	);

	sts_gap_timer u_gap (
		.pclk           (pclk),
		.presetn        (presetn),
		.frame_done     (frame_done),
		.frame_long     (frame_long),
		.short_gap_attr (st.gap[GAP_SHORT_POS +: 16]),
		.long_gap_attr  (st.gap[GAP_LONG_POS +: 16]),
		.gap_busy       (gap_busy_i)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st               = st;
		next_st.slot_start    = 1'b0;
		next_st.beacon_start  = 1'b0;

		// apb slave, zero wait states
		setup                 = psel & ~penable;
		wr                    = psel & penable & st.pready & pwrite & ~st.pslverr;
		next_st.pready        = setup;
		next_st.pslverr       = 1'b0;
		next_st.prdata        = '0;
		if (setup)
		begin
			unique case (paddr)
				OFS_CTRL:   next_st.prdata = st.ctrl;
				OFS_FRAME:  next_st.prdata = st.frame;
				OFS_GAP:    next_st.prdata = st.gap;
				OFS_FSK:    next_st.prdata = st.fsk;
				OFS_DRIFT:  next_st.prdata = {24'h000000, st.drift};
				OFS_STATUS: next_st.prdata = {16'h0000, gap_busy_i, cfg_ok, st.fsk_st, st.running,
					st.beacon_once, st.period, 3'h0, st.slot_idx};
				OFS_COUNT:  next_st.prdata = {8'h00, st.cnt};
				default:    next_st.pslverr = 1'b1;
			endcase
		end
		if (wr)
		begin
			unique case (paddr)
				OFS_CTRL:   next_st.ctrl  = pwdata;
				OFS_FRAME:  next_st.frame = pwdata;
				OFS_GAP:    next_st.gap   = pwdata;
				OFS_FSK:    next_st.fsk   = pwdata;
				OFS_DRIFT:  next_st.drift = pwdata[7:0];
				default:    next_st.ctrl  = st.ctrl;
			endcase
		end
		breq                         = beacon_req_in | next_st.ctrl[CTRL_BREQ_BIT];
		next_st.ctrl[CTRL_BREQ_BIT]  = 1'b0;

		// decoded configuration
		enabled      = st.ctrl[CTRL_EN_BIT];
		mode         = st.ctrl[CTRL_MODE_POS +: 2];
		nonbeacon    = ~beacon_net & cfg_ok;
		sframe       = enabled & (mode == MODE_BEACON_NET) & beacon_net & cfg_ok;
		cfp_first    = st.frame[FRAME_CFP_POS +: 5];
		beacon_len   = {8'h00, st.frame[FRAME_BLEN_POS +: 16]};
		cfp_bound    = slot_len * {19'h00000, cfp_first};
		wrap_at      = beacon_interval - 24'h000001 + {{16{st.drift[7]}}, st.drift};
		cfp_ok       = sframe & ~active_none & (cfp_first < SLOT_COUNT_CONST)
			& ((cfp_bound >= beacon_len + MIN_CONTENTION_LEN) | st.frame[FRAME_GROW_BIT]);
		ifs_len      = {8'h00, st.gap[GAP_LONG_POS +: 16]};
		sync_count   = st.fsk[FSK_SYNC_POS +: 4];
		data_count   = st.fsk[FSK_DATA_POS +: 8];
		inactive_len = st.fsk[FSK_IDLE_POS +: 16];

		// superframe counter, restarted at each beacon
		if (sframe)
		begin
			next_st.running     = 1'b1;
			next_st.beacon_once = 1'b0;
			if (!st.running || st.cnt >= wrap_at)
			begin
				next_st.cnt          = '0;
				next_st.slot_cnt     = '0;
				next_st.slot_idx     = '0;
				next_st.beacon_start = 1'b1;
				next_st.slot_start   = 1'b1;
			end
			else
			begin
				next_st.cnt = st.cnt + 24'h000001;
				if (st.slot_cnt >= slot_len - 24'h000001)
				begin
					next_st.slot_cnt = '0;
					if (st.slot_idx != SLOT_COUNT_CONST)
						next_st.slot_idx = st.slot_idx + 5'h01;
					next_st.slot_start = (st.slot_idx + 5'h01) < SLOT_COUNT_CONST;
				end
				else
					next_st.slot_cnt = st.slot_cnt + 24'h000001;
			end
		end
		else if (st.beacon_once)
		begin
			next_st.cnt = st.cnt + 24'h000001;
			if (st.cnt >= beacon_len - 24'h000001)
				next_st.beacon_once = 1'b0;
		end
		else
		begin
			next_st.running  = 1'b0;
			next_st.cnt      = '0;
			next_st.slot_cnt = '0;
			next_st.slot_idx = '0;
			if (breq && enabled && mode == MODE_BEACON_NET && nonbeacon)
			begin
				next_st.beacon_once  = 1'b1;
				next_st.beacon_start = 1'b1;
			end
		end

		// period flag
		if (sframe || next_st.beacon_once)
		begin
			if (next_st.cnt < beacon_len)
				next_st.period = PER_BEACON;
			else if (!sframe || active_none || next_st.cnt >= active_duration)
				next_st.period = PER_INACTIVE;
			else if (cfp_ok && next_st.slot_idx >= cfp_first)
				next_st.period = PER_CFP;
			else
				next_st.period = PER_CONTENTION;
		end
		else
			next_st.period = enabled ? PER_CONTENTION : PER_INACTIVE;

		// access method for the period
		unique case (next_st.period)
			PER_BEACON:     next_st.access = ACC_DIRECT;
			PER_CFP:        next_st.access = ACC_DIRECT;
			PER_INACTIVE:   next_st.access = ACC_NONE;
			PER_CONTENTION:
			begin
				if (sframe)
					next_st.access = ACC_SLOTTED;
				else if (mode == MODE_BEACON_NET || mode == MODE_ROLLING_FREQ)
					next_st.access = ACC_UNSLOTTED;
				else
					next_st.access = ACC_DIRECT;
			end
		endcase
		next_st.cca_enable  = (next_st.access == ACC_SLOTTED) | (next_st.access == ACC_UNSLOTTED);
		next_st.gts_allowed = cfp_ok;

		// does the transaction fit before its period ends
		limited    = sframe & ((next_st.period == PER_CONTENTION) | (next_st.period == PER_CFP));
		period_end = (next_st.period == PER_CONTENTION && cfp_ok) ? cfp_bound : active_duration;
		if (!limited)
			next_st.tx_fits = next_st.period != PER_INACTIVE;
		else
			next_st.tx_fits = (period_end > next_st.cnt)
				&& (period_end - next_st.cnt >= tx_len + ifs_len);

		// receiver enable
		if (sframe)
			next_st.rx_enable = next_st.period != PER_INACTIVE;
		else if (mode == MODE_BEACON_NET)
			next_st.rx_enable = st.ctrl[CTRL_RXIDLE_BIT];
		else
			next_st.rx_enable = enabled;

		// idle pattern fill for visibility
		next_st.idle_pattern = enabled & st.ctrl[CTRL_VIS_BIT] & ~tx_busy
			& (st.ctrl[CTRL_INFRA_BIT]
				? ((next_st.period == PER_CONTENTION) | slot_uplink | ~slot_used)
				: ~slot_used);

		// frequency-shift frame sequence
		if (!(enabled && mode == MODE_ROLLING_FREQ))
		begin
			next_st.fsk_st   = FSK_FDP;
			next_st.fsk_cnt  = '0;
			next_st.fsk_idle = '0;
		end
		else
		begin
			unique case (st.fsk_st)
				FSK_FDP:
				begin
					next_st.fsk_cnt = '0;
					if (pkt_done)
						next_st.fsk_st = (sync_count == 4'h0) ? FSK_DATA : FSK_SYNC;
				end
				FSK_SYNC:
				begin
					if (pkt_done)
					begin
						next_st.fsk_cnt = st.fsk_cnt + 8'h01;
						if (st.fsk_cnt + 8'h01 >= {4'h0, sync_count})
						begin
							next_st.fsk_st  = FSK_DATA;
							next_st.fsk_cnt = '0;
						end
					end
				end
				FSK_DATA:
				begin
					next_st.fsk_idle = '0;
					if (pkt_done)
					begin
						next_st.fsk_cnt = st.fsk_cnt + 8'h01;
						if (st.fsk_cnt + 8'h01 >= data_count)
						begin
							next_st.fsk_cnt = '0;
							next_st.fsk_st  = (inactive_len == 16'h0000) ? FSK_FDP : FSK_IDLE;
						end
					end
				end
				FSK_IDLE:
				begin
					next_st.fsk_idle = st.fsk_idle + 16'h0001;
					if (st.fsk_idle + 16'h0001 >= inactive_len)
						next_st.fsk_st = FSK_FDP;
				end
			endcase
		end
		next_st.freq_label_en = enabled & (mode == MODE_ROLLING_FREQ) & (next_st.fsk_st == FSK_FDP);
		next_st.low_power_ok  = (next_st.fsk_st == FSK_IDLE) & st.ctrl[CTRL_LP_BIT];
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st       <= '0;
			st.ctrl  <= CTRL_RST;
			st.frame <= FRAME_RST;
			st.gap   <= GAP_RST;
			st.fsk   <= FSK_RST;
			st.drift <= DRIFT_RST;
		end
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata        = st.prdata;
	assign pready        = st.pready;
	assign pslverr       = st.pslverr;
	assign period        = st.period;
	assign slot_index    = st.slot_idx;
	assign slot_start    = st.slot_start;
	assign beacon_start  = st.beacon_start;
	assign access        = st.access;
	assign cca_enable    = st.cca_enable;
	assign tx_fits       = st.tx_fits;
	assign gts_allowed   = st.gts_allowed;
	assign rx_enable     = st.rx_enable;
	assign idle_pattern  = st.idle_pattern;
	assign gap_busy      = gap_busy_i;
	assign fsk_kind      = st.fsk_st;
	assign freq_label_en = st.freq_label_en;
	assign low_power_ok  = st.low_power_ok;

endmodule : sts_scheduler

// >>> sim/sts_peer_model.sv
// peer model: remote device sending frames over the link
`timescale 1ns/100ps
module sts_peer_model
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic send,
	input  wire logic long_f,
	output logic      tx_busy,
	output logic      frame_done,
	output logic      frame_long
);
	logic [2:0] left;
	// ----------------------------------------
	// one whole frame, then a done pulse
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			left <= 3'h0;
			frame_done <= 1'b0;
			frame_long <= 1'b0;
		end
		else
		begin
			left <= send ? 3'h4 : left - {2'h0, left != 3'h0};
			frame_done <= left == 3'h1;
			frame_long <= (left == 3'h1) ? long_f : ~frame_long;
		end
	assign tx_busy = left != 3'h0;
endmodule : sts_peer_model

// >>> sim/sts_properties.sv
// checker: period, slot and bus timing properties of the scheduler
`timescale 1ns/100ps
module sts_properties
	import sts_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input sts_period_t     period,
	input wire logic [4:0] slot_index,
	input wire logic       slot_start,
	input wire logic       beacon_start,
	input sts_access_t     access,
	input wire logic       cca_enable
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence beacon_end_s;
		period == PER_BEACON ##1 period != PER_BEACON;
	endsequence
	a_apb_answer: assert property (setup_s |=> pready)
		else $error("no ready after setup");
	a_beacon_open: assert property (beacon_start |-> period == PER_BEACON)
		else $error("beacon not flagged");
	a_cap_follows: assert property (beacon_end_s |-> period inside {PER_CONTENTION, PER_INACTIVE})
		else $error("bad period after beacon");
	a_cfp_boundary: assert property (period == PER_CFP && $past(period) != PER_CFP
		|-> $past(period) == PER_CONTENTION && slot_start)
		else $error("cfp entry off boundary");
	a_cfp_access: assert property (period == PER_CFP |-> access != ACC_UNSLOTTED)
		else $error("random access in cfp");
	a_cap_slotted: assert property (period == PER_CONTENTION && access != ACC_DIRECT
		|-> cca_enable && access != ACC_NONE)
		else $error("contention access wrong");
	a_slot_step: assert property (slot_start && slot_index != 5'h0
		|-> slot_index == $past(slot_index) + 5'h1)
		else $error("slot index skipped");
	a_direct_no_cca: assert property (access == ACC_DIRECT |-> !cca_enable)
		else $error("channel check in direct access");
endmodule : sts_properties

bind sts_scheduler sts_properties u_props (.pclk, .presetn, .psel, .penable, .pready, .period,
	.slot_index, .slot_start, .beacon_start, .access, .cca_enable);

// >>> sim/sts_scheduler_test.sv
// testbench: registers, superframe, non-beacon, gap and mode checks
`timescale 1ns/100ps
module sts_scheduler_test;
	import sts_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, beacon_req_in, send, long_f, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, slot_start, beacon_start, tx_busy, frame_done, frame_long;
	logic        cca_enable, tx_fits, gts_allowed, rx_enable, idle_pattern, gap_busy, freq_label_en, low_power_ok;
	logic        pkt_done, slot_used, slot_uplink;
	logic [23:0] tx_len;
	logic [4:0]  slot_index;
	sts_period_t period;
	sts_access_t access;
	sts_fsk_t    fsk_kind;
	int          err_total = 0, check_count = 0, n, slots;
	sts_scheduler uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .beacon_req_in, .tx_len, .tx_busy, .slot_used, .slot_uplink,
		.frame_done, .frame_long, .pkt_done, .period, .slot_index, .slot_start, .beacon_start,
		.access, .cca_enable, .tx_fits, .gts_allowed, .rx_enable, .idle_pattern, .gap_busy, .fsk_kind,
		.freq_label_en, .low_power_ok);
	sts_peer_model peer (.pclk, .presetn, .send, .long_f, .tx_busy, .frame_done, .frame_long);
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task wait_ev(input int s, input int lim);
		for (n = 1; n <= lim; n++)
		begin
			@(negedge pclk);
			slots += (slot_start === 1'b1);
			if ((s == 0 && beacon_start === 1'b1) || (s == 1 && period === PER_CONTENTION)
				|| (s == 2 && period === PER_CFP) || (s == 3 && period === PER_INACTIVE)
				|| (s == 4 && gap_busy === 1'b1) || (s == 5 && gap_busy !== 1'b1))
				break;
		end
	endtask : wait_ev
	task print_verdict;
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		logic [31:0] rst [5];
		rst = '{CTRL_RST, FRAME_RST, GAP_RST, FSK_RST, {24'h0, DRIFT_RST}};
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk("reset value", rst[i], q);
		end
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
	endtask : t_regs
	task t_super;
		tx_len <= 24'(12 * BASE_SLOT_LEN - 32 - GAP_RST[31:16]);
		apb(1'b1, OFS_DRIFT, 32'h00000005);
		apb(1'b1, OFS_FRAME, 32'h0020000c);
		apb(1'b1, OFS_CTRL, 32'h00000101);
		wait_ev(0, 20);
		slots = 0;
		wait_ev(1, 99);
		chk("beacon length", 32'd32, n);
		chk("tx fits contention", 32'h1, {31'h0, tx_fits});
		wait_ev(2, 999);
		chk("cfp start", 12 * BASE_SLOT_LEN - 32, n);
		chk("cfp slot index", 32'd12, {27'h0, slot_index});
		chk("tx fits cfp", 32'h0, {31'h0, tx_fits});
		chk("guaranteed slots", 32'h1, {31'h0, gts_allowed});
		wait_ev(3, 999);
		chk("active end", BASE_SUPERFRAME_LEN - 12 * BASE_SLOT_LEN, n);
		wait_ev(0, 1999);
		chk("beacon interval", BASE_SUPERFRAME_LEN + 32'd5, n);
		chk("slot count", SLOT_COUNT_CONST, slots);
		apb(1'b1, OFS_FRAME, 32'h00200005);
		repeat (2) @(negedge pclk);
		chk("short cfp dropped", 32'h0, {31'h0, gts_allowed});
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask : t_super
	task t_nonbeacon;
		apb(1'b1, OFS_CTRL, 32'h000003ff);
		wait_ev(0, 2500);
		chk("no beacon", 32'd2501, n);
		chk("rx when idle", 32'h1, {31'h0, rx_enable});
		@(posedge pclk);
		beacon_req_in <= 1'b1;
		@(posedge pclk);
		beacon_req_in <= 1'b0;
		wait_ev(0, 9);
		chk("requested beacon", 32'h1, {31'h0, beacon_start});
		wait_ev(1, 99);
		chk("unslotted", {30'h0, ACC_UNSLOTTED}, {30'h0, access});
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask : t_nonbeacon
	task t_gap;
		for (int i = 0; i < 2; i++)
		begin
			@(posedge pclk);
			send <= 1'b1;
			long_f <= i[0];
			@(posedge pclk);
			send <= 1'b0;
			wait_ev(4, 20);
			wait_ev(5, 99);
			chk("gap length", i ? GAP_RST[31:16] : GAP_RST[15:0], n);
		end
	endtask : t_gap
	task t_modes;
		for (int m = 1; m < 3; m++)
		begin
			apb(1'b1, OFS_CTRL, 32'(32'h100 | (m << 12)));
			repeat (3) @(negedge pclk);
			chk("direct access", {30'h0, ACC_DIRECT}, {30'h0, access});
			chk("no channel check", 32'h0, {31'h0, cca_enable});
		end
	endtask : t_modes
	task pulse;
		@(posedge pclk);
		pkt_done <= 1'b1;
		@(posedge pclk);
		pkt_done <= 1'b0;
		@(negedge pclk);
	endtask : pulse
	task t_fsk;
		apb(1'b1, OFS_FSK, 32'h00110003);
		apb(1'b1, OFS_CTRL, 32'h00023500);
		repeat (2) @(negedge pclk);
		chk("label in fdp", 32'h1, {31'h0, freq_label_en});
		chk("visible idle fill", 32'h1, {31'h0, idle_pattern});
		pulse;
		chk("sync packet", {30'h0, FSK_SYNC}, {30'h0, fsk_kind});
		pulse;
		chk("data frame", {30'h0, FSK_DATA}, {30'h0, fsk_kind});
		pulse;
		chk("inactive frame", {30'h0, FSK_IDLE}, {30'h0, fsk_kind});
		chk("low power", 32'h1, {31'h0, low_power_ok});
		repeat (3) @(negedge pclk);
		chk("inactive length", {30'h0, FSK_FDP}, {30'h0, fsk_kind});
		@(posedge pclk);
		slot_used <= 1'b1;
		slot_uplink <= 1'b1;
		repeat (2) @(negedge pclk);
		chk("mobile used slot", 32'h0, {31'h0, idle_pattern});
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask : t_fsk
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial
	begin
		{psel, penable, pwrite, beacon_req_in, send, long_f, presetn, pkt_done, slot_used, slot_uplink} = '0;
		tx_len = '0;
		paddr = '0;
		pwdata = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_super;
		t_nonbeacon;
		t_gap;
		t_modes;
		t_fsk;
		print_verdict;
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		print_verdict;
	end
endmodule : sts_scheduler_test
